// file: common/wd_pkg.sv
// Shared constants for the watchdog control and reset-cause flag block.
package wd_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W          = 4;
	localparam logic [3:0] REG_RESET_CAUSE = 4'h0;
	localparam logic [3:0] REG_WD_CONTROL  = 4'h1;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RC_POWERON  = 0;
	localparam int RC_PIN      = 1;
	localparam int RC_BROWNOUT = 2;
	localparam int RC_WD       = 3;
	localparam int WC_IRQ_FLAG  = 7;
	localparam int WC_IRQ_EN    = 6;
	localparam int WC_PERIOD_HI = 5;
	localparam int WC_UNLOCK    = 4;
	localparam int WC_ENABLE    = 3;
	localparam int WC_PERIOD_LO = 0;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] PERIOD_RESET  = 4'h0;
	localparam logic [3:0] PERIOD_MAX    = 4'h9;
	localparam logic [3:0] RC_UNUSED     = 4'h0;
	localparam logic [7:0] RDATA_IDLE    = 8'h00;
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 40_000_000;
	localparam int OSC_HZ          = 128_000;
	localparam int OSC_DIV         = CLK_HZ / OSC_HZ;
	localparam int BASE_OSC_CYCLES = 2048;
	localparam int OSC_CNT_W       = 21;

endpackage

// file: hw/wd_timer.sv
// Watchdog oscillator-tick divider and time-out counter.
`timescale 1ns/100ps
`default_nettype none

module wd_timer #(
	parameter int DIV   = wd_pkg::OSC_DIV,
	parameter int BASE  = wd_pkg::BASE_OSC_CYCLES,
	parameter int CNT_W = wd_pkg::OSC_CNT_W
) (
	input  wire logic       mclk_in,
	input  wire logic       rst_b_in,
	input  wire logic       restart_in,
	input  wire logic       run_in,
	input  wire logic [3:0] period_in,
	output logic            timeout_out
);

	localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

	typedef struct packed {
		logic [DW-1:0]    div;
		logic [CNT_W-1:0] cnt;
		logic             timeout;
	} timer_state_type;

	timer_state_type s;
	timer_state_type next_s;
	logic [CNT_W-1:0] limit;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// The divider makes a one-cycle oscillator tick; the counter counts ticks
	// up to the selected period and then pulses a time-out for one cycle.
	always_comb begin
		next_s = s;
		next_s.timeout = 1'b0;
		limit = CNT_W'(BASE) << period_in;
		if (!run_in || restart_in) begin
			next_s.div = '0;
			next_s.cnt = '0;
		end else if (s.div == DW'(DIV - 1)) begin
			next_s.div = '0;
			if (s.cnt == limit - CNT_W'(1)) begin
				next_s.cnt = '0;
				next_s.timeout = 1'b1;
			end else begin
				next_s.cnt = s.cnt + CNT_W'(1);
			end
		end else begin
			next_s.div = s.div + DW'(1);
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign timeout_out = s.timeout;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_KICK_RESTARTS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		restart_in |=> (s.cnt == '0) && !timeout_out)
		else $error("counter not restarted by kick");

endmodule // wd_timer

`default_nettype wire

// file: hw/wd_ctrl.sv
// Watchdog control register, reset-cause flags and time-out actions.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Watchdog reset sets flag; power-on or zero clears.
// - Brown-out reset sets flag; power-on or zero clears.
// - Pin reset sets flag; power-on or zero clears.
// - Power-on sets its flag; only zero write clears.
// - Upper four reset-cause bits read zero.
// - Interrupt-mode time-out sets time-out flag.
// - Vector taken or written one clears flag.
// - Interrupt needs global and time-out enables.
// - Enable bits choose stop, interrupt or reset.
// - Time-out with enable clears interrupt enable.
// - Unlock bit self-clears four cycles later.
// - Enable clears only while unlock reads one.
// - Period changes only while unlock is set.
// - Safety level two keeps watchdog enabled.
// - Level one: reset flag forces enable on.
// - Period codes double from 2048 oscillator cycles.
// - Reserved period codes use a valid setting.
// - Counter advances on 128 kHz oscillator ticks.
// - Kick restarts the watchdog counter.
// - Always-on fuse selects the safety level.
// - Reset-mode time-out gives one-cycle reset pulse.
module wd_ctrl #(
	parameter int DIV   = wd_pkg::OSC_DIV,
	parameter int BASE  = wd_pkg::BASE_OSC_CYCLES,
	parameter int CNT_W = wd_pkg::OSC_CNT_W
) (
	input  wire logic                      mclk_in,
	input  wire logic                      rst_b_in,
	input  wire logic [wd_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [7:0]                wdata_in,
	input  wire logic                      wr_in,
	input  wire logic                      rd_in,
	output logic      [7:0]                rdata_out,
	input  wire logic                      brownout_reset_in,
	input  wire logic                      pin_reset_in,
	input  wire logic                      always_on_fuse_in,
	input  wire logic                      kick_in,
	input  wire logic                      irq_ack_in,
	input  wire logic                      global_irq_enable_in,
	output logic                           timeout_irq_out,
	output logic                           sys_reset_out
);

	typedef struct packed {
		logic       wd_reset_flag;
		logic       brownout_reset_flag;
		logic       pin_reset_flag;
		logic       poweron_reset_flag;
		logic       timeout_irq_flag;
		logic       timeout_irq_enable;
		logic       change_unlock;
		logic [2:0] unlock_cnt;
		logic       wd_enable_bit;
		logic [3:0] period_select;
		logic       level2;
		logic [7:0] rdata;
		logic       sys_reset;
	} ctrl_state_type;

	ctrl_state_type s;
	ctrl_state_type next_s;
	logic           eff_enable;
	logic           dev_reset;
	logic           timeout;
	logic           run;
	logic           wr_ctrl;
	logic           wr_cause;
	logic [3:0]     period_eff;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Reserved period codes fall back to the longest valid period.
	function automatic logic [3:0] clamp_period(input logic [3:0] code);
		clamp_period = (code > wd_pkg::PERIOD_MAX) ? wd_pkg::PERIOD_MAX : code;
	endfunction

	// Gathers the period field from its split position in a control byte.
	function automatic logic [3:0] period_field(input logic [7:0] b);
		period_field = {b[wd_pkg::WC_PERIOD_HI], b[wd_pkg::WC_PERIOD_LO +: 3]};
	endfunction

	// Effective enable folds in the fuse and the reset-flag override.
	assign eff_enable = s.wd_enable_bit | s.level2 | s.wd_reset_flag;
	assign dev_reset  = brownout_reset_in | pin_reset_in | s.sys_reset;
	assign run        = eff_enable | s.timeout_irq_enable;
	assign period_eff = clamp_period(s.period_select);
	assign wr_ctrl    = wr_in && (addr_in == wd_pkg::REG_WD_CONTROL);
	assign wr_cause   = wr_in && (addr_in == wd_pkg::REG_RESET_CAUSE);

	// ----------------------------------------------------------------
	// Timer
	// ----------------------------------------------------------------
	// Oscillator ticks are enable pulses on the system clock, so the
	// time-out arrives as a one-cycle pulse with no crossing to lose it.
	wd_timer #(
		.DIV   (DIV),
		.BASE  (BASE),
		.CNT_W (CNT_W)
	) wd_timer_i (
		.mclk_in     (mclk_in),
		.rst_b_in    (rst_b_in),
		.restart_in  (kick_in | dev_reset),
		.run_in      (run),
		.period_in   (period_eff),
		.timeout_out (timeout)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Flag clears by write or vector come before the time-out set, so that set wins
	// in the same cycle; the device reset block comes after them and wins over all but the time-out's sys_reset set.
	always_comb begin
		next_s = s;
		next_s.sys_reset = 1'b0;
		next_s.rdata = wd_pkg::RDATA_IDLE;

		// Unlock window countdown.
		if (s.change_unlock) begin
			if (s.unlock_cnt == wd_pkg::UNLOCK_CYCLES - 3'h1) begin
				next_s.change_unlock = 1'b0;
				next_s.unlock_cnt = 3'h0;
			end else begin
				next_s.unlock_cnt = s.unlock_cnt + 3'h1;
			end
		end

		// Reset-cause writes: a zero clears a flag, a one leaves it.
		if (wr_cause) begin
			next_s.wd_reset_flag       = s.wd_reset_flag & wdata_in[wd_pkg::RC_WD];
			next_s.brownout_reset_flag = s.brownout_reset_flag &
				wdata_in[wd_pkg::RC_BROWNOUT];
			next_s.pin_reset_flag      = s.pin_reset_flag & wdata_in[wd_pkg::RC_PIN];
			next_s.poweron_reset_flag  = s.poweron_reset_flag &
				wdata_in[wd_pkg::RC_POWERON];
		end

		// Control writes.
		if (wr_ctrl) begin
			if (wdata_in[wd_pkg::WC_IRQ_FLAG]) begin
				next_s.timeout_irq_flag = 1'b0;
			end
			next_s.timeout_irq_enable = wdata_in[wd_pkg::WC_IRQ_EN];
			if (s.change_unlock) begin
				next_s.period_select = period_field(wdata_in);
			end
			if (wdata_in[wd_pkg::WC_ENABLE]) begin
				next_s.wd_enable_bit = 1'b1;
			end else if (s.change_unlock && !s.level2 && !s.wd_reset_flag) begin
				next_s.wd_enable_bit = 1'b0;
			end
			if (wdata_in[wd_pkg::WC_UNLOCK] && wdata_in[wd_pkg::WC_ENABLE]) begin
				next_s.change_unlock = 1'b1;
				next_s.unlock_cnt = 3'h0;
			end
		end

		// The vector being taken clears the flag.
		if (irq_ack_in) begin
			next_s.timeout_irq_flag = 1'b0;
		end

		// Time-out action by enable bits.
		if (timeout) begin
			if (s.timeout_irq_enable) begin
				next_s.timeout_irq_flag = 1'b1;
				if (eff_enable) begin
					next_s.timeout_irq_enable = 1'b0;
				end
			end else if (eff_enable) begin
				next_s.sys_reset = 1'b1;
			end
		end

		// Device reset: record its cause and restore the control defaults.
		if (dev_reset) begin
			if (s.sys_reset) begin
				next_s.wd_reset_flag = 1'b1;
			end
			if (brownout_reset_in) begin
				next_s.brownout_reset_flag = 1'b1;
			end
			if (pin_reset_in) begin
				next_s.pin_reset_flag = 1'b1;
			end
			next_s.timeout_irq_flag = 1'b0;
			next_s.timeout_irq_enable = 1'b0;
			next_s.change_unlock = 1'b0;
			next_s.unlock_cnt = 3'h0;
			next_s.wd_enable_bit = s.level2;
			next_s.period_select = wd_pkg::PERIOD_RESET;
		end

		// Register read, answered in the following cycle.
		if (rd_in) begin
			if (addr_in == wd_pkg::REG_RESET_CAUSE) begin
				next_s.rdata = {wd_pkg::RC_UNUSED, s.wd_reset_flag,
					s.brownout_reset_flag, s.pin_reset_flag, s.poweron_reset_flag};
			end else if (addr_in == wd_pkg::REG_WD_CONTROL) begin
				next_s.rdata = {s.timeout_irq_flag, s.timeout_irq_enable,
					s.period_select[3], s.change_unlock, eff_enable,
					s.period_select[2:0]};
			end else begin
				next_s.rdata = wd_pkg::RDATA_IDLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Power-on reset sets its own flag and clears the other causes; the
	// fuse is caught here, with the clock, and held until the next one.
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			s <= '0;
			s.poweron_reset_flag <= 1'b1;
			s.level2 <= always_on_fuse_in;
			s.wd_enable_bit <= always_on_fuse_in;
			s.period_select <= wd_pkg::PERIOD_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_out       = s.rdata;
	assign sys_reset_out   = s.sys_reset;
	assign timeout_irq_out = s.timeout_irq_flag & s.timeout_irq_enable &
		global_irq_enable_in;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence unlock_start;
		wr_ctrl && wdata_in[wd_pkg::WC_UNLOCK] && wdata_in[wd_pkg::WC_ENABLE] && !dev_reset;
	endsequence

	sequence quiet_window;
		!dev_reset && !(wr_ctrl && wdata_in[wd_pkg::WC_UNLOCK]);
	endsequence

	sequence irq_timeout;
		timeout && s.timeout_irq_enable && !dev_reset;
	endsequence

	AST_WD_FLAG_SET: assert property (s.sys_reset |=> s.wd_reset_flag)
		else $error("watchdog reset flag not set");

	AST_BO_FLAG_SET: assert property (brownout_reset_in |=> s.brownout_reset_flag)
		else $error("brown-out flag not set");

	AST_PIN_FLAG_SET: assert property (pin_reset_in |=> s.pin_reset_flag)
		else $error("pin reset flag not set");

	AST_POR_FLAG_HOLD: assert property (s.poweron_reset_flag && !wr_cause |=>
		s.poweron_reset_flag)
		else $error("power-on flag lost without a write");

	AST_WD_FLAG_CLEAR: assert property (wr_cause && !wdata_in[wd_pkg::RC_WD] &&
		!dev_reset |=> !s.wd_reset_flag)
		else $error("watchdog reset flag not cleared by zero write");

	AST_POR_FLAG_CLEAR: assert property (wr_cause && !wdata_in[wd_pkg::RC_POWERON] |=>
		!s.poweron_reset_flag)
		else $error("power-on flag not cleared by zero write");

	// A device reset puts the control fields back to their defaults.
	AST_DEV_DEFAULTS: assert property (dev_reset |=> s.wd_enable_bit == s.level2 &&
		!s.change_unlock && s.period_select == wd_pkg::PERIOD_RESET)
		else $error("control not back to defaults after device reset");

	AST_CAUSE_UPPER_ZERO: assert property (rd_in && addr_in == wd_pkg::REG_RESET_CAUSE
		|=> rdata_out[7:4] == 4'h0)
		else $error("upper reset-cause bits not zero");

	AST_IRQ_FLAG_SET: assert property (irq_timeout |=> s.timeout_irq_flag)
		else $error("time-out flag not set in interrupt mode");

	AST_IRQ_ACK_CLEAR: assert property (irq_ack_in && !timeout |=> !s.timeout_irq_flag)
		else $error("time-out flag not cleared by vector");

	AST_IRQ_GATING: assert property (timeout_irq_out |-> global_irq_enable_in &&
		s.timeout_irq_enable && s.timeout_irq_flag)
		else $error("interrupt requested without enables");

	// Clears by vector or write act one cycle later, so they are kept out here.
	AST_STOPPED_QUIET: assert property (!run && !dev_reset && !irq_ack_in &&
		!wr_ctrl |=> !sys_reset_out && $stable(s.timeout_irq_flag))
		else $error("stopped watchdog acted");

	AST_IRQ_EN_AUTOCLEAR: assert property (irq_timeout ##0 eff_enable |=>
		!s.timeout_irq_enable && s.timeout_irq_flag)
		else $error("interrupt enable not cleared on time-out");

	// Unlock stands in the four cycles after its write and drops in the fifth.
	AST_UNLOCK_WINDOW: assert property (unlock_start ##1 quiet_window[*4] |->
		s.change_unlock ##1 (!s.change_unlock && $past(s.change_unlock)))
		else $error("unlock window not four cycles");

	AST_ENABLE_CLEARED: assert property (wr_ctrl && s.change_unlock &&
		!wdata_in[wd_pkg::WC_ENABLE] && !s.level2 && !s.wd_reset_flag && !dev_reset |=>
		!s.wd_enable_bit)
		else $error("unlocked disable not accepted");

	AST_PERIOD_TAKEN: assert property (wr_ctrl && s.change_unlock && !dev_reset |=>
		s.period_select == {$past(wdata_in[wd_pkg::WC_PERIOD_HI]),
		$past(wdata_in[wd_pkg::WC_PERIOD_LO +: 3])})
		else $error("unlocked period write not taken");

	AST_DISABLE_LOCKED: assert property (wr_ctrl && !s.change_unlock && !dev_reset &&
		eff_enable |=> eff_enable)
		else $error("watchdog disabled without unlock");

	AST_PERIOD_LOCKED: assert property (!s.change_unlock && !dev_reset |=>
		s.period_select == $past(s.period_select))
		else $error("period changed without unlock");

	AST_LEVEL2_ON: assert property (s.level2 |-> s.wd_enable_bit)
		else $error("level two watchdog disabled");

	AST_WD_FLAG_FORCES: assert property (rd_in && addr_in == wd_pkg::REG_WD_CONTROL &&
		s.wd_reset_flag |=> rdata_out[wd_pkg::WC_ENABLE])
		else $error("reset flag did not force enable");

	AST_PERIOD_VALID: assert property (period_eff <= wd_pkg::PERIOD_MAX)
		else $error("reserved period code in use");

	AST_RESET_PULSE: assert property ($rose(sys_reset_out) |=> !sys_reset_out ##1
		!sys_reset_out)
		else $error("reset pulse longer than one cycle");

endmodule // wd_ctrl

`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the watchdog control and reset-cause flag block.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	localparam int DIV  = 2;
	localparam int BASE = 4;

	logic       mclk_in              = 1'b0;
	logic       rst_b_in             = 1'b0;
	logic [3:0] addr_in              = 4'h0;
	logic [7:0] wdata_in             = 8'h00;
	logic       wr_in                = 1'b0;
	logic       rd_in                = 1'b0;
	logic       brownout_reset_in    = 1'b0;
	logic       pin_reset_in         = 1'b0;
	logic       always_on_fuse_in    = 1'b0;
	logic       kick_in              = 1'b1;
	logic       irq_ack_in           = 1'b0;
	logic       global_irq_enable_in = 1'b0;
	logic [7:0] rdata_out;
	logic       timeout_irq_out;
	logic       sys_reset_out;
	logic       prev_rst             = 1'b0;
	logic [7:0] v;
	int         err_count            = 0;
	int         total_checks         = 0;
	int         pulses               = 0;
	int         cyc;
	logic [3:0] codes [5]            = '{4'h0, 4'h1, 4'h3, 4'h9, 4'hf};

	// Clock at 40 MHz.
	always #12.5 mclk_in = ~mclk_in;

	wd_ctrl #(.DIV(DIV), .BASE(BASE), .CNT_W(wd_pkg::OSC_CNT_W)) wd_ctrl_i (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.brownout_reset_in(brownout_reset_in), .pin_reset_in(pin_reset_in),
		.always_on_fuse_in(always_on_fuse_in), .kick_in(kick_in), .irq_ack_in(irq_ack_in),
		.global_irq_enable_in(global_irq_enable_in), .timeout_irq_out(timeout_irq_out),
		.sys_reset_out(sys_reset_out));

	// Counts reset pulses and flags any pulse longer than one cycle.
	always @(posedge mclk_in) begin
		if (sys_reset_out === 1'b1) pulses <= pulses + 1;
		if (sys_reset_out === 1'b1 && prev_rst === 1'b1) begin
			$display("[FAIL] reset pulse width expected 1 seen 2");
			err_count++;
		end
		prev_rst <= sys_reset_out;
	end

	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge mclk_in);
		err_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// Drives one bus cycle; strobes stay as set until the next call.
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		wr_in    <= w;
		rd_in    <= r;
		addr_in  <= a;
		wdata_in <= d;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask

	task automatic idle(input int k);
		repeat (k) bus(1'b0, 1'b0, 4'h0, 8'h00);
	endtask

	// Read data is sampled just after the edge that follows the strobe.
	task automatic get(input logic [3:0] a, output logic [7:0] d);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1;
		d = rdata_out;
	endtask

	task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		get(a, d);
		check(name, exp, d);
	endtask

	// Opening write, second write, then a read once the unlock window is over.
	task automatic timed(input logic [7:0] open, input logic [7:0] d, input logic [7:0] exp);
		wr(4'h1, open);
		wr(4'h1, d);
		idle(5);
		rd("control", 4'h1, exp);
	endtask

	task automatic pulse(input int which);
		@(posedge mclk_in);
		case (which)
			0: brownout_reset_in <= 1'b1;
			1: pin_reset_in <= 1'b1;
			default: irq_ack_in <= 1'b1;
		endcase
		@(posedge mclk_in);
		brownout_reset_in <= 1'b0;
		pin_reset_in      <= 1'b0;
		irq_ack_in        <= 1'b0;
	endtask

	task automatic kick(input logic k);
		@(posedge mclk_in);
		kick_in <= k;
	endtask

	task automatic poll_flag(output logic [7:0] d);
		int k;
		k = 0;
		d = 8'h00;
		while (d[7] !== 1'b1 && k < 300) begin
			get(4'h1, d);
			k++;
		end
		if (k >= 300) begin
			$display("[FAIL] timeout flag expected 1 seen 0");
			err_count++;
			summarize();
		end
	endtask

	task automatic wait_reset(output int c);
		c = 0;
		while (sys_reset_out !== 1'b1 && c < 5000) begin
			@(posedge mclk_in);
			#1;
			c++;
		end
		if (c >= 5000) begin
			$display("[FAIL] sys_reset_out expected 1 seen 0");
			err_count++;
			summarize();
		end
	endtask

	function automatic logic [7:0] enc(input logic [3:0] p);
		return {2'b00, p[3], 2'b01, p[2:0]};
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		rd("cause", 4'h0, 8'h01);
		idle(1);
		#1;
		check("rdata idle", 8'h00, rdata_out);
		rd("control", 4'h1, 8'h00);
		wr(4'h5, 8'hff);
		rd("unmapped", 4'h5, 8'h00);
		rd("cause", 4'h0, 8'h01);
		$display("test reset done");
		pulse(0);
		rd("cause", 4'h0, 8'h05);
		pulse(1);
		rd("cause", 4'h0, 8'h07);
		wr(4'h0, 8'hff);
		rd("cause", 4'h0, 8'h07);
		wr(4'h0, 8'h00);
		rd("cause", 4'h0, 8'h00);
		pulse(1);
		rd("cause", 4'h0, 8'h02);
		$display("test flags done");
		idle(40);
		check("pulses stopped", 8'h00, pulses[7:0]);
		wr(4'h1, 8'h08);
		rd("control", 4'h1, 8'h08);
		idle(40);
		check("pulses kicked", 8'h00, pulses[7:0]);
		wr(4'h1, 8'h00);
		rd("control", 4'h1, 8'h08);
		wr(4'h1, 8'h0d);
		rd("control", 4'h1, 8'h08);
		wr(4'h1, 8'h18);
		rd("control", 4'h1, 8'h18);
		idle(6);
		rd("control", 4'h1, 8'h08);
		timed(8'h18, 8'h05, 8'h05);
		wr(4'h1, 8'h03);
		rd("control", 4'h1, 8'h05);
		wr(4'h1, 8'h1d);
		idle(6);
		wr(4'h1, 8'h05);
		rd("control", 4'h1, 8'h0d);
		timed(8'h1d, 8'h00, 8'h00);
		$display("test unlock done");
		timed(8'h18, 8'h45, 8'h45);
		kick(1'b0);
		poll_flag(v);
		check("flag set", 8'hc5, v);
		check("irq masked", 8'h00, {7'h00, timeout_irq_out});
		@(posedge mclk_in);
		global_irq_enable_in <= 1'b1;
		idle(1);
		#1;
		check("irq out", 8'h01, {7'h00, timeout_irq_out});
		pulse(2);
		rd("control", 4'h1, 8'h45);
		check("irq cleared", 8'h00, {7'h00, timeout_irq_out});
		poll_flag(v);
		wr(4'h1, 8'hc5);
		rd("control", 4'h1, 8'h45);
		check("pulses irq", 8'h00, pulses[7:0]);
		kick(1'b1);
		timed(8'h1d, 8'h4d, 8'h4d);
		kick(1'b0);
		poll_flag(v);
		check("enable clears irq en", 8'h8d, v);
		wait_reset(cyc);
		kick(1'b1);
		rd("cause", 4'h0, 8'h0a);
		rd("control", 4'h1, 8'h08);
		timed(8'h18, 8'h00, 8'h08);
		wr(4'h0, 8'h00);
		timed(8'h18, 8'h00, 8'h00);
		$display("test interrupt done");
		foreach (codes[i]) begin
			timed(8'h18, enc(codes[i]), enc(codes[i]));
			kick(1'b0);
			wait_reset(cyc);
			kick(1'b1);
			total_checks++;
			if (cyc < DIV * (BASE << ((codes[i] > 4'h9) ? 9 : codes[i])) ||
				cyc > DIV * (BASE << ((codes[i] > 4'h9) ? 9 : codes[i])) + DIV + 3) begin
				$display("[FAIL] cycles code %h expected %0d seen %0d", codes[i],
					DIV * (BASE << ((codes[i] > 4'h9) ? 9 : codes[i])), cyc);
				err_count++;
			end
		end
		idle(2);
		check("pulses total", 8'h06, pulses[7:0]);
		rd("cause", 4'h0, 8'h08);
		$display("test periods done");
		pulse(0);
		rd("cause", 4'h0, 8'h0c);
		@(posedge mclk_in);
		always_on_fuse_in <= 1'b1;
		rst_b_in          <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		rd("cause", 4'h0, 8'h01);
		rd("control", 4'h1, 8'h08);
		timed(8'h18, 8'h00, 8'h08);
		timed(8'h18, 8'h0b, 8'h0b);
		wr(4'h1, 8'h09);
		rd("control", 4'h1, 8'h0b);
		$display("test level two done");
		summarize();
	end
endmodule // testbench

`default_nettype wire
